// ---- rtl/pmch_pkg.sv ----
// package: offsets, field layout and fixed values of the power management capability header
`default_nettype none
package pmch_pkg;

  // ****************************************
  // item offsets and access
  // ****************************************
  localparam logic [1:0] PMCH_OFS_IDENT = 2'h0;
  localparam logic [1:0] PMCH_OFS_NEXT  = 2'h1;
  localparam logic [1:0] PMCH_OFS_CAPS  = 2'h2;
  localparam logic [1:0] PMCH_OFS_CAPSH = 2'h3;

  // ****************************************
  // fixed values
  // ****************************************
  localparam logic [7:0] PMCH_IDENT_VAL  = 8'h01;
  localparam logic [7:0] PMCH_NEXT_END   = 8'h00;
  localparam logic [2:0] PMCH_VERSION    = 3'h1;
  localparam logic [7:0] PMCH_RESET_BYTE = 8'h00;

  // ****************************************
  // capabilities word field positions
  // ****************************************
  localparam int PMCH_POS_VERSION = 0;
  localparam int PMCH_POS_CLOCK   = 3;
  localparam int PMCH_POS_DSI     = 5;
  localparam int PMCH_POS_ONE     = 9;
  localparam int PMCH_POS_TWO     = 10;
  localparam int PMCH_POS_WAKE    = 11;
  localparam int PMCH_POS_D3COLD  = 15;

  // ****************************************
  // access states
  // ****************************************
  typedef enum logic [1:0] {
    PMCH_IDLE = 2'b00,
    PMCH_RESP = 2'b01
  } pmch_state_t;

  // config access request: dword address within item, byte enables, write flag
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  byte_en;
    logic        dword_sel;
    logic [31:0] wdata;
  } pmch_req_t;

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } pmch_rsp_t;

  // fixed design-time capability settings
  typedef struct packed {
    logic [4:0] wake_state_mask;
    logic       state_two_supported;
    logic       state_one_supported;
    logic       needs_init;
    logic       wake_needs_bus_clock;
    logic [7:0] next_pointer;
  } pmch_cfg_t;

endpackage
`default_nettype wire

// ---- rtl/pmch_aux_sync.sv ----
// two-flop synchroniser for the auxiliary supply sense pin
`timescale 1ns/1ps
`default_nettype none
module pmch_aux_sync (
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } pmch_sync_st_t;

  pmch_sync_st_t st_q;
  pmch_sync_st_t st_d;

  always_comb begin
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.sync;
endmodule
`default_nettype wire

// ---- rtl/pmch_caps_word.sv ----
// builds the read-only capabilities word from fixed settings and supply sense
`timescale 1ns/1ps
`default_nettype none
module pmch_caps_word
  import pmch_pkg::*;
(
  input  wire pmch_pkg::pmch_cfg_t i_cfg,
  input  wire logic                i_aux_present,
  output logic [15:0]              o_caps
);
  import pmch_pkg::*;

  logic [4:0] mask;
  logic       any_wake;

  always_comb begin
    mask = i_cfg.wake_state_mask;
    // cold-state wake only claimed with auxiliary power sensed
    mask[PMCH_POS_D3COLD - PMCH_POS_WAKE] = i_cfg.wake_state_mask[4] & i_aux_present;
    any_wake = |mask;
    o_caps = 16'h0000;
    o_caps[PMCH_POS_WAKE +: 5] = mask;
    o_caps[PMCH_POS_TWO] = i_cfg.state_two_supported;
    o_caps[PMCH_POS_ONE] = i_cfg.state_one_supported;
    o_caps[PMCH_POS_DSI] = i_cfg.needs_init;
    o_caps[PMCH_POS_CLOCK] = i_cfg.wake_needs_bus_clock & any_wake;
    o_caps[PMCH_POS_VERSION +: 3] = PMCH_VERSION;
  end
endmodule
`default_nettype wire

// ---- rtl/pmch_header.sv ----
// power management capability header: config-space read-only register group
`timescale 1ns/1ps
`default_nettype none
module pmch_header
  import pmch_pkg::*;
#(
  parameter logic [4:0] WAKE_MASK  = 5'h00,
  parameter logic       HAS_TWO    = 1'b0,
  parameter logic       HAS_ONE    = 1'b0,
  parameter logic       NEEDS_INIT = 1'b0,
  parameter logic       WAKE_CLOCK = 1'b0,
  parameter logic [7:0] NEXT_PTR   = 8'h00
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_srst,
  input  wire pmch_pkg::pmch_req_t i_req,
  input  wire logic                i_aux_sense,
  output pmch_pkg::pmch_rsp_t      o_rsp,
  output logic                     o_busy
);
  import pmch_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pmch_state_t state;
    logic        done;
    logic [31:0] rdata;
  } pmch_hdr_st_t;

  pmch_hdr_st_t st_q;
  pmch_hdr_st_t st_d;
  pmch_cfg_t    cfg;
  logic         aux_ok;
  logic [15:0]  caps;
  logic [31:0]  dword0;

  // masks a dword by byte lanes so partial reads return only selected bytes
  function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = be[i] ? d[i*8 +: 8] : PMCH_RESET_BYTE;
    end
    return r;
  endfunction

  // ****************************************
  // capability contents
  // ****************************************
  always_comb begin
    cfg.wake_state_mask      = WAKE_MASK;
    cfg.state_two_supported  = HAS_TWO;
    cfg.state_one_supported  = HAS_ONE;
    cfg.needs_init           = NEEDS_INIT;
    cfg.wake_needs_bus_clock = WAKE_CLOCK;
    cfg.next_pointer         = NEXT_PTR;
  end

  pmch_aux_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    (i_aux_sense),
    .o_sync     (aux_ok)
  );

  pmch_caps_word u_caps (
    .i_cfg         (cfg),
    .i_aux_present (aux_ok),
    .o_caps        (caps)
  );

  // fixed identifier, one header instance per function
  assign dword0 = {caps, cfg.next_pointer, PMCH_IDENT_VAL};

  // ****************************************
  // access handling
  // ****************************************
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    case (st_q.state)
      PMCH_IDLE: begin
        if (i_req.valid) begin
          st_d.state = PMCH_RESP;
          st_d.done  = 1'b1;
          // writes ignored: nothing here is writable
          if (i_req.write) begin
            st_d.rdata = 32'h0000_0000;
          end else if (!i_req.dword_sel) begin
            st_d.rdata = lane_mask(dword0, i_req.byte_en);
          end else begin
            st_d.rdata = 32'h0000_0000;
          end
        end
      end
      PMCH_RESP: begin
        st_d.state = PMCH_IDLE;
      end
      default: begin
        st_d.state = PMCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rsp.done  = st_q.done;
  assign o_rsp.rdata = st_q.rdata;
  assign o_busy      = (st_q.state == PMCH_RESP);

  // ****************************************
  // checks
  // ****************************************
  a_ident_read: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.valid && !o_busy && !i_req.write && !i_req.dword_sel && i_req.byte_en[0])
      |=> (o_rsp.done && o_rsp.rdata[7:0] == 8'h01))
    else $error("identifier byte not 01h");
  a_next_read: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.valid && !o_busy && !i_req.write && !i_req.dword_sel && i_req.byte_en[1])
      |=> (o_rsp.rdata[15:8] == NEXT_PTR))
    else $error("next pointer wrong");
  a_version_bits: assert property (@(posedge i_core_clk) disable iff (i_srst)
    caps[2:0] == 3'b001)
    else $error("version field wrong");
  a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    caps[8:6] == 3'b000 && caps[4] == 1'b0)
    else $error("reserved caps bits not zero");
  a_upper_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.valid && !o_busy && i_req.dword_sel) |=> (o_rsp.done && o_rsp.rdata == 32'h0))
    else $error("unmapped read not zero");
  a_write_done: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.valid && !o_busy && i_req.write) |=> (o_rsp.done ##1 !o_rsp.done))
    else $error("write not completed");
  a_caps_stable: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $past(i_req.valid && i_req.write) |-> $stable(caps[14:0]))
    else $error("caps changed by write");
  a_clock_nowake: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (caps[15:11] == 5'h00) |-> !caps[3])
    else $error("clock bit set without wake");
  a_cold_aux: assert property (@(posedge i_core_clk) disable iff (i_srst)
    caps[15] |-> aux_ok)
    else $error("cold wake without aux power");
  a_lane_mask: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.valid && !o_busy && !i_req.write && !i_req.byte_en[3]) |=> o_rsp.rdata[31:24] == 8'h00)
    else $error("unselected lane not zero");

  a_done_pulse: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_rsp.done |=> !o_rsp.done)
    else $error("done longer than one cycle");
  a_rdata_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !(i_req.valid && !o_busy) |=> $stable(o_rsp.rdata))
    else $error("read data changed without access");

  c_read_low: cover property (@(posedge i_core_clk) i_req.valid && !i_req.write && !i_req.dword_sel);
  c_read_high: cover property (@(posedge i_core_clk) i_req.valid && !i_req.write && i_req.dword_sel);
  c_write: cover property (@(posedge i_core_clk) i_req.valid && i_req.write);
  c_aux_up: cover property (@(posedge i_core_clk) $rose(aux_ok));
endmodule
`default_nettype wire

// ---- test/pmch_host.sv ----
// host model: issues config reads and writes to the capability header
`timescale 1ns/1ps
`default_nettype none
module pmch_host (
  input  wire logic                i_core_clk,
  input  wire pmch_pkg::pmch_rsp_t i_rsp,
  output pmch_pkg::pmch_req_t      o_req,
  output logic                     o_late
);
  import pmch_pkg::*;

  initial begin
    o_req  = '0;
    o_late = 1'b0;
  end

  // ****************************************
  // one access, any size of byte lanes
  // ****************************************
  task automatic access(input logic wr, input logic [3:0] be, input logic dsel,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge i_core_clk);
    o_req <= '{valid: 1'b1, write: wr, byte_en: be, dword_sel: dsel, wdata: wd};
    do begin
      @(negedge i_core_clk);
      n++;
    end while (i_rsp.done !== 1'b1 && n < 8);
    if (n >= 8) o_late = 1'b1;
    rd = i_rsp.rdata;
    // released lines show a changed pattern, not the last request
    o_req <= '{valid: 1'b0, write: ~wr, byte_en: ~be, dword_sel: ~dsel, wdata: ~wd};
  endtask
endmodule
`default_nettype wire

// ---- test/power_mgmt_capability_header_tb.sv ----
// testbench for the power management capability header
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_capability_header_tb;
  import pmch_pkg::*;

  // instance a: uneven wake mask, state two, init flag; instance b: needs clock but has no wake state
  localparam logic [31:0] DW_A = 32'hCC21_4001;
  localparam logic [31:0] DW_B = 32'h0001_0001;

  logic        core_clk;
  logic        srst;
  logic        aux;
  logic        late;
  logic        busy_a;
  logic        busy_b;
  logic [31:0] rd;
  pmch_req_t   req;
  pmch_rsp_t   rsp_a;
  pmch_rsp_t   rsp_b;
  int          err_total;
  int          total_checks;
  logic [3:0]  sizes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};

  pmch_header #(.WAKE_MASK(5'h19), .HAS_TWO(1'b1), .NEEDS_INIT(1'b1), .NEXT_PTR(8'h40)) u_pmch_header (
    .i_core_clk(core_clk), .i_srst(srst), .i_req(req), .i_aux_sense(aux), .o_rsp(rsp_a), .o_busy(busy_a));
  pmch_header #(.WAKE_CLOCK(1'b1)) u_pmch_header_b (
    .i_core_clk(core_clk), .i_srst(srst), .i_req(req), .i_aux_sense(aux), .o_rsp(rsp_b), .o_busy(busy_b));
  pmch_host u_pmch_host (.i_core_clk(core_clk), .i_rsp(rsp_a), .o_req(req), .o_late(late));

  // ****************************************
  // checking helpers
  // ****************************************
  function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) if (!be[i]) d[8*i+:8] = 8'h00;
    return d;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_both(input logic [3:0] be, input logic dsel, input logic [31:0] ea, input logic [31:0] eb);
    u_pmch_host.access(1'b0, be, dsel, 32'h0000_0000, rd);
    check_word(rd, lanes(ea, be), "read a");
    check_word(rsp_b.rdata, lanes(eb, be), "read b");
    check_word({31'h0, rsp_b.done}, 32'h1, "done b");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog and test sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    err_total++;
    stop_test();
  end

  initial begin
    srst = 1'b1;
    aux = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    rd_both(4'hF, 1'b0, DW_A & 32'h7FFF_FFFF, DW_B);
    check_word({30'h0, busy_a, busy_b}, 32'h3, "busy after take");
    aux = 1'b1;
    repeat (4) @(negedge core_clk);
    foreach (sizes[i]) rd_both(sizes[i], 1'b0, DW_A, DW_B);
    u_pmch_host.access(1'b1, 4'hF, 1'b0, 32'hFFFF_FFFF, rd);
    check_word(rd, 32'h0000_0000, "write data");
    rd_both(4'hF, 1'b0, DW_A, DW_B);
    u_pmch_host.access(1'b1, 4'hF, 1'b1, 32'hA5A5_5A5A, rd);
    check_word(rd, 32'h0000_0000, "reserved write data");
    rd_both(4'hF, 1'b1, 32'h0, 32'h0);
    aux = 1'b0;
    repeat (4) @(negedge core_clk);
    rd_both(4'hC, 1'b0, DW_A & 32'h7FFF_FFFF, DW_B);
    check_word({31'h0, late}, 32'h0, "answer late");
    stop_test();
  end
endmodule
`default_nettype wire
